// file: fsc_cycle_decode.sv
// Cycle decoder of a synchronous flow-through burst memory.
// Assumes the controller shares clk and meets setup to it; only the
// sleep request and output gate arrive from outside that timing.
`default_nettype none
`timescale 1ns/1ps

module fsc_cycle_decode #(
  parameter int ADDR_W = fsc_pkg::ADDR_W,   // Word address width
  parameter int LANES  = fsc_pkg::LANES     // Byte lanes, two or four
) (
  input  wire logic              clk,                // 20 MHz clock
  input  wire logic              nrst,               // Async reset, low
  input  wire logic              chip_select_low_a,  // Select, active low
  input  wire logic              chip_select_high,   // Select, active high
  input  wire logic              chip_select_low_b,  // Select, active low
  input  wire logic              sleep_request,      // Async sleep, high
  input  wire logic              advance_or_load,    // High advance, low load
  input  wire logic              write_strobe_n,     // Write, active low
  input  wire logic [LANES-1:0]  byte_lane_write_n,  // Lane selects, low
  input  wire logic              output_gate_n,      // Async output gate
  input  wire logic              clock_qualify_n,    // Low lets edge act
  input  wire logic              burst_order_select, // High interleaved
  input  wire logic [ADDR_W-1:0] addr_in,            // External address
  output logic      [ADDR_W-1:0] mem_addr,           // Array address
  output logic      [LANES-1:0]  mem_lane_we,        // Lanes to store
  output logic                   mem_read,           // Array read cycle
  output logic                   data_drive_en,      // Data/parity drivers
  output fsc_pkg::fsc_cycle_t    cycle,              // Decoded cycle
  output logic                   asleep              // Low power state
);

  // ****************************************
  // Elaboration checks
  // ****************************************
  // The carrier is sized by the package, so ADDR_W must match it and LANES must be one of its two lane counts
  if (ADDR_W != fsc_pkg::ADDR_W || (LANES != fsc_pkg::LANES && LANES != fsc_pkg::LANES_NARROW)
      || LANES > fsc_pkg::LANES) begin : g_bad_size
    $error("fsc_cycle_decode: unsupported width");
  end

  // ****************************************
  // Reset release
  // ****************************************
  logic [1:0] rst_sync_q;   // Release chain
  logic       rst_n;        // Synchronised reset

  // Assert at once, release after two edges
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ****************************************
  // State and next state
  // ****************************************
  fsc_pkg::fsc_state_t s_q;   // Registered state
  fsc_pkg::fsc_state_t s_d;   // Next state
  logic [1:0]          low;   // Stepped low address
  logic [1:0]          cnt_nx; // Next burst count
  logic                selected;
  logic                any_lane;
  logic [fsc_pkg::LANES-1:0] lanes_w; // Lane selects, low active, widened

  // Low bits for the next access of the burst
  assign cnt_nx = 2'(s_q.cnt + 2'h1);
  fsc_burst_step u_step (
    .base  (s_q.base_lo),
    .count (cnt_nx),
    .order (s_q.order),
    .low   (low)
  );

  assign selected = !chip_select_low_a && chip_select_high && !chip_select_low_b;
  // Unused upper lanes of the narrow variant read as not selected
  for (genvar i = 0; i < fsc_pkg::LANES; i++) begin : g_lane
    if (i < LANES) begin : g_used
      assign lanes_w[i] = byte_lane_write_n[i];
    end else begin : g_pad
      assign lanes_w[i] = 1'b1;
    end
  end
  assign any_lane = ~&lanes_w;

  // Decode the sampled controls into the next cycle
  always_comb begin
    s_d            = s_q;
    s_d.sleep_sync = {s_q.sleep_sync[0], sleep_request};
    if (s_q.sleep_sync[1]) begin
      // Sleep beats every other input; contents are left alone
      s_d.cyc      = fsc_pkg::CYC_SLEEP;
      s_d.asleep   = 1'b1;
      s_d.in_burst = 1'b0;
      s_d.rd_allow = 1'b0;
      s_d.lane_we  = fsc_pkg::LANES_OFF;
    end else if (clock_qualify_n) begin
      // Edge ignored except by the sleep synchroniser, wait state inserted
      s_d.cyc = s_q.cyc;
    end else if (!advance_or_load) begin
      s_d.cnt   = fsc_pkg::CNT_RST;
      s_d.asleep = 1'b0;
      s_d.order = burst_order_select;
      if (!selected) begin
        s_d.cyc      = fsc_pkg::CYC_DESELECT;
        s_d.in_burst = 1'b0;
        s_d.rd_allow = 1'b0;
        s_d.lane_we  = fsc_pkg::LANES_OFF;
      end else if (write_strobe_n) begin
        // Read start; gate decides real or dummy
        s_d.cyc      = fsc_pkg::CYC_READ;
        s_d.addr_lo  = addr_in[1:0];
        s_d.op_write = 1'b0;
        s_d.in_burst = 1'b1;
        s_d.addr_hi  = addr_in[ADDR_W-1:2];
        s_d.base_lo  = addr_in[1:0];
        s_d.rd_allow = 1'b1;
        s_d.lane_we  = fsc_pkg::LANES_OFF;
      end else if (any_lane) begin
        s_d.cyc      = fsc_pkg::CYC_WRITE;
        s_d.addr_lo  = addr_in[1:0];
        s_d.op_write = 1'b1;
        s_d.in_burst = 1'b1;
        s_d.addr_hi  = addr_in[ADDR_W-1:2];
        s_d.base_lo  = addr_in[1:0];
        s_d.rd_allow = 1'b0;
        s_d.lane_we  = ~lanes_w;
      end else begin
        // Abort start: address kept as it was, nothing stored
        s_d.cyc      = fsc_pkg::CYC_ABORT;
        s_d.op_write = 1'b1;
        s_d.in_burst = 1'b1;
        s_d.rd_allow = 1'b0;
        s_d.lane_we  = fsc_pkg::LANES_OFF;
      end
    end else if (!s_q.in_burst) begin
      // No burst open, selects not even looked at
      s_d.cyc      = fsc_pkg::CYC_DESEL_CONT;
      s_d.asleep   = 1'b0;
      s_d.rd_allow = 1'b0;
      s_d.lane_we  = fsc_pkg::LANES_OFF;
    end else begin
      // Continue: selects and write strobe ignored
      s_d.cnt = cnt_nx;
      s_d.addr_lo = low;
      s_d.asleep  = 1'b0;
      if (!s_q.op_write) begin
        s_d.cyc      = fsc_pkg::CYC_READ_CONT;
        s_d.rd_allow = 1'b1;
        s_d.lane_we  = fsc_pkg::LANES_OFF;
      end else if (any_lane) begin
        s_d.cyc      = fsc_pkg::CYC_WRITE_CONT;
        s_d.rd_allow = 1'b0;
        s_d.lane_we  = ~lanes_w;
      end else begin
        s_d.cyc      = fsc_pkg::CYC_ABORT_CONT;
        s_d.rd_allow = 1'b0;
        s_d.lane_we  = fsc_pkg::LANES_OFF;
      end
    end
  end

  // Register the state; reset gives a deselected device
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q          <= '0;
      s_q.cyc      <= fsc_pkg::CYC_DESELECT;
      s_q.cnt      <= fsc_pkg::CNT_RST;
      s_q.lane_we  <= fsc_pkg::LANES_OFF;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Stepped low bits are registered, so the address comes from flops
  assign mem_addr    = {s_q.addr_hi, s_q.addr_lo};
  assign mem_lane_we = s_q.lane_we[LANES-1:0];
  assign mem_read    = s_q.rd_allow;
  assign cycle       = s_q.cyc;
  assign asleep      = s_q.asleep;
  // Gate is not clocked: it only opens drivers in a read cycle.
  // Write cycles never set rd_allow, which masks the gate.
  assign data_drive_en = s_q.rd_allow && !output_gate_n;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_read_start;
    !clock_qualify_n && !advance_or_load && selected && write_strobe_n && !s_q.sleep_sync[1]
      |=> cycle == fsc_pkg::CYC_READ && mem_read && mem_addr == $past(addr_in);
  endproperty
  a_read_start: assert property (p_read_start) else $error("read start missed");

  property p_read_cont;
    !clock_qualify_n && advance_or_load && s_q.in_burst && !s_q.op_write && !s_q.sleep_sync[1]
      |=> cycle == fsc_pkg::CYC_READ_CONT && mem_addr[ADDR_W-1:2] == $past(mem_addr[ADDR_W-1:2]);
  endproperty
  a_read_cont: assert property (p_read_cont) else $error("read continue wrong");

  property p_dummy;
    mem_read |-> data_drive_en == !output_gate_n;
  endproperty
  a_dummy: assert property (p_dummy) else $error("dummy read drove pins");

  property p_write_start;
    !clock_qualify_n && !advance_or_load && selected && !write_strobe_n && any_lane
      && !s_q.sleep_sync[1] |=> cycle == fsc_pkg::CYC_WRITE && mem_lane_we == ~$past(byte_lane_write_n);
  endproperty
  a_write_start: assert property (p_write_start) else $error("write start wrong");

  property p_abort;
    cycle inside {fsc_pkg::CYC_ABORT, fsc_pkg::CYC_ABORT_CONT} |-> mem_lane_we == '0 && !data_drive_en;
  endproperty
  a_abort: assert property (p_abort) else $error("abort stored data");

  property p_stall;
    clock_qualify_n && !s_q.sleep_sync[1] |=> $stable(mem_addr) && $stable(cycle) && $stable(mem_lane_we);
  endproperty
  a_stall: assert property (p_stall) else $error("stall changed state");

  property p_write_mask;
    mem_lane_we != '0 |-> !data_drive_en;
  endproperty
  a_write_mask: assert property (p_write_mask) else $error("drivers enabled in write");

  property p_deselect;
    !clock_qualify_n && !advance_or_load && !selected && !s_q.sleep_sync[1]
      |=> cycle == fsc_pkg::CYC_DESELECT && !mem_read && !data_drive_en;
  endproperty
  a_deselect: assert property (p_deselect) else $error("deselect missed");

  property p_sleep;
    sleep_request [*3] |=> asleep && !data_drive_en && mem_lane_we == '0;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep not entered");

  property p_type_kept;
    !clock_qualify_n && advance_or_load && s_q.in_burst && s_q.op_write && !s_q.sleep_sync[1]
      |=> !mem_read;
  endproperty
  a_type_kept: assert property (p_type_kept) else $error("burst type changed");

  c_read:   cover property (cycle == fsc_pkg::CYC_READ ##1 cycle == fsc_pkg::CYC_READ_CONT);
  c_write:  cover property (cycle == fsc_pkg::CYC_WRITE ##1 cycle == fsc_pkg::CYC_WRITE_CONT);
  c_sleep:  cover property (asleep ##1 !asleep);
  c_wrap:   cover property (s_q.cnt == fsc_pkg::CNT_LAST);

endmodule : fsc_cycle_decode

`default_nettype wire

// file: fsc_pkg.sv
// Shared constants, cycle codes and state carrier for the cycle decoder,
// plus the small burst address stepper used by it.
// Assumes one clock shared with the memory controller.
`default_nettype none

package fsc_pkg;
  // ****************************************
  // Sizes and reset values
  // ****************************************
  localparam int          ADDR_W      = 19;    // Word address width, wide variant
  localparam int          LANES       = 4;     // Byte lanes, wide variant
  localparam int          LANES_NARROW = 2;    // Byte lanes, narrow variant
  localparam int          BURST_W     = 2;     // Burst counter width
  localparam logic [1:0]  CNT_RST     = 2'h0;  // Burst count after reset
  localparam logic [1:0]  CNT_LAST    = 2'h3;  // Fourth access of a burst
  localparam logic [3:0]  LANES_OFF   = 4'h0;  // No lane written
  localparam int          SYNC_STAGES = 2;     // Flops on the sleep input

  // ****************************************
  // Decoded cycle kinds
  // ****************************************
  typedef enum logic [3:0] {
    CYC_DESELECT,
    CYC_DESEL_CONT,
    CYC_READ,
    CYC_READ_CONT,
    CYC_WRITE,
    CYC_WRITE_CONT,
    CYC_ABORT,
    CYC_ABORT_CONT,
    CYC_SLEEP
  } fsc_cycle_t;

  // State of the decoder, all but the reset release chain
  typedef struct packed {
    logic [1:0]        sleep_sync;  // Sleep request synchroniser
    fsc_cycle_t        cyc;         // Cycle decoded at the last edge
    logic              op_write;    // Burst type latched at burst start
    logic              in_burst;    // A burst is open
    logic [ADDR_W-1:2] addr_hi;     // Upper address, fixed during a burst
    logic [1:0]        base_lo;     // Start of the burst within four
    logic [1:0]        cnt;         // Accesses done since the start
    logic              order;       // Burst order latched at start
    logic              rd_allow;    // Read cycle, drivers may open
    logic [LANES-1:0]  lane_we;     // Lanes written this cycle
    logic [1:0]        addr_lo;     // Low address of this access
    logic              asleep;      // Sleep state, kept in a flop
  } fsc_state_t;
endpackage : fsc_pkg

`timescale 1ns/1ps

// ****************************************
// Burst address stepper
// ****************************************
module fsc_burst_step (
  input  wire logic [1:0] base,   // First low address of the burst
  input  wire logic [1:0] count,  // Access number within the burst
  input  wire logic       order,  // High for interleaved order
  output logic      [1:0] low     // Low address bits to use
);
  // Linear adds and wraps, interleaved flips bits
  always_comb begin
    if (order) begin
      low = base ^ count;
    end else begin
      low = 2'(base + count);
    end
  end
endmodule : fsc_burst_step

`default_nettype wire

// file: fsc_ctrl_model.sv
// Memory controller model that drives the decoder's control inputs.
// Assumes one shared clock; the bench calls its tasks one after another.
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Controller model
// ****************************************
module fsc_ctrl_model (
  input  wire logic        clk,                // Shared clock
  output var  logic        chip_select_low_a,  // Select, active low
  output var  logic        chip_select_high,   // Select, active high
  output var  logic        chip_select_low_b,  // Select, active low
  output var  logic        sleep_request,      // Sleep, active high
  output var  logic        advance_or_load,    // High advance, low load
  output var  logic        write_strobe_n,     // Write, active low
  output var  logic [3:0]  byte_lane_write_n,  // Lane selects, active low
  output var  logic        output_gate_n,      // Output gate, active low
  output var  logic        clock_qualify_n,    // Low lets the edge act
  output var  logic        burst_order_select, // High interleaved
  output var  logic [18:0] addr_in             // Word address
);
  // Idle at time zero: deselected, loading, no lanes
  initial begin
    {chip_select_low_a, chip_select_high, chip_select_low_b} = 3'h5;
    {sleep_request, advance_or_load, write_strobe_n} = 3'h1;
    byte_lane_write_n = 4'hf;
    {output_gate_n, clock_qualify_n, burst_order_select} = 3'h0;
    addr_in = 19'h00000;
  end

  // One cycle: drive just after an edge, return 5 ns after the edge that took it
  task automatic op(input logic [2:0] sel, input logic adv, input logic we_n, input logic [3:0] lanes,
                    input logic cq_n, input logic ord, input logic [18:0] addr);
    {chip_select_low_a, chip_select_high, chip_select_low_b} = sel;
    advance_or_load    = adv;   // Bench advances once after the last deselect
    write_strobe_n     = we_n;
    byte_lane_write_n  = lanes; // Wanted lanes driven every write cycle
    clock_qualify_n    = cq_n;
    burst_order_select = ord;
    // Address is don't-care while advancing: show a changing pattern
    addr_in = adv ? ~addr_in : addr;
    @(posedge clk);
    #5;
  endtask : op

  // Asynchronous gate and sleep levels, settled after 1 ns
  task automatic aux(input logic gate_n, input logic slp);
    output_gate_n = gate_n;
    sleep_request = slp;
    #1;
  endtask : aux
endmodule : fsc_ctrl_model
`default_nettype wire

// file: test_fsc_cycle_decode.sv
// Self-checking bench for the cycle decoder, driven through the controller model.
// Assumes the package and design files are compiled first.
`timescale 1ns/1ps
`default_nettype none

module test_fsc_cycle_decode;
  logic                clk = 1'b0;    // 20 MHz clock
  logic                nrst;          // Reset, active low
  logic                cs_a, cs_h, cs_b, slp, adv, we_n, gate_n, cq_n, ord;
  logic [3:0]          lanes;         // Lane selects
  logic [18:0]         addr;          // Controller address
  logic [18:0]         mem_addr;      // Array address
  logic [3:0]          lane_we;       // Lanes stored
  logic                mem_read, drv, asleep;
  fsc_pkg::fsc_cycle_t cycle;         // Decoded cycle
  int                  errors      = 0;
  int                  checks_done = 0;
  logic [2:0]          desel [3] = '{3'h7, 3'h3, 3'h0}; // Both low selects off, then low b alone, then high alone

  always #25 clk = ~clk;

  fsc_ctrl_model ctrl_u (.clk(clk), .chip_select_low_a(cs_a), .chip_select_high(cs_h),
    .chip_select_low_b(cs_b), .sleep_request(slp), .advance_or_load(adv), .write_strobe_n(we_n),
    .byte_lane_write_n(lanes), .output_gate_n(gate_n), .clock_qualify_n(cq_n),
    .burst_order_select(ord), .addr_in(addr));

  fsc_cycle_decode dut_u (.clk(clk), .nrst(nrst), .chip_select_low_a(cs_a), .chip_select_high(cs_h),
    .chip_select_low_b(cs_b), .sleep_request(slp), .advance_or_load(adv), .write_strobe_n(we_n),
    .byte_lane_write_n(lanes), .output_gate_n(gate_n), .clock_qualify_n(cq_n),
    .burst_order_select(ord), .addr_in(addr), .mem_addr(mem_addr), .mem_lane_we(lane_we),
    .mem_read(mem_read), .data_drive_en(drv), .cycle(cycle), .asleep(asleep));

  // ****************************************
  // Comparison helpers
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Cycle kind and driver enable together
  task automatic ck(input fsc_pkg::fsc_cycle_t c, input logic d);
    chk(32'(cycle), 32'(c));
    chk(32'(drv), 32'(d));
  endtask : ck

  // Array side: address, lanes, read flag
  task automatic ckm(input logic [18:0] a, input logic [3:0] l, input logic r);
    chk(32'(mem_addr), 32'(a));
    chk(32'(lane_we), 32'(l));
    chk(32'(mem_read), 32'(r));
  endtask : ckm

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop

  // Watchdog: the tests need well under 100 cycles
  initial begin
    repeat (400) @(posedge clk);
    errors++;
    report_and_stop();
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    nrst = 1'b0;
    ctrl_u.aux(1'b0, 1'b0);
    repeat (3) @(posedge clk);
    #5;
    nrst = 1'b1;
    ck(fsc_pkg::CYC_DESELECT, 1'b0);
    repeat (2) @(posedge clk);
    #5;
    ck(fsc_pkg::CYC_DESELECT, 1'b0);
    $display("test reset done");
    // Linear burst with gate closed (dummy), then interleaved with gate open
    for (int m = 0; m < 2; m++) begin
      ctrl_u.aux(m == 0, 1'b0);
      ctrl_u.op(3'h2, 1'b0, 1'b1, 4'hf, 1'b0, m[0], 19'h12345);
      ck(fsc_pkg::CYC_READ, m[0]);
      ckm(19'h12345, 4'h0, 1'b1);
      for (int i = 1; i < 4; i++) begin
        // Selects off, write low, order flipped: all ignored while advancing
        ctrl_u.op(3'h5, 1'b1, 1'b0, 4'h0, 1'b0, ~m[0], 19'h0);
        ck(fsc_pkg::CYC_READ_CONT, m[0]);
        ckm({17'h048d1, (m == 0) ? 2'(1 + i) : 2'(1 ^ i)}, 4'h0, 1'b1);
      end
    end
    ctrl_u.aux(1'b1, 1'b0);
    ck(fsc_pkg::CYC_READ_CONT, 1'b0);
    ctrl_u.aux(1'b0, 1'b0);
    ck(fsc_pkg::CYC_READ_CONT, 1'b1);
    // Qualifier high: a new load must not act
    ctrl_u.op(3'h2, 1'b0, 1'b0, 4'h0, 1'b1, 1'b0, 19'h7ffff);
    ck(fsc_pkg::CYC_READ_CONT, 1'b1);
    ckm(19'h12346, 4'h0, 1'b1);
    $display("test read done");
    // Write burst with gate low, then a continue abort and an abort start
    ctrl_u.op(3'h2, 1'b0, 1'b0, 4'ha, 1'b0, 1'b0, 19'h0abc8);
    ck(fsc_pkg::CYC_WRITE, 1'b0);
    ckm(19'h0abc8, 4'h5, 1'b0);
    ctrl_u.op(3'h5, 1'b1, 1'b1, 4'h6, 1'b0, 1'b1, 19'h0);
    ck(fsc_pkg::CYC_WRITE_CONT, 1'b0);
    ckm(19'h0abc9, 4'h9, 1'b0);
    ctrl_u.op(3'h5, 1'b1, 1'b1, 4'hf, 1'b0, 1'b0, 19'h0);
    ck(fsc_pkg::CYC_ABORT_CONT, 1'b0);
    ckm(19'h0abca, 4'h0, 1'b0);
    ctrl_u.op(3'h2, 1'b0, 1'b0, 4'hf, 1'b0, 1'b0, 19'h00111);
    ck(fsc_pkg::CYC_ABORT, 1'b0);
    ckm(19'h0abca, 4'h0, 1'b0);
    $display("test write done");
    // Both low selects off, then low b alone, then high alone, then an advance with nothing open
    foreach (desel[k]) begin
      ctrl_u.op(desel[k], 1'b0, 1'b1, 4'h0, 1'b0, 1'b0, 19'h00020);
      ck(fsc_pkg::CYC_DESELECT, 1'b0);
      chk(32'(mem_read), 32'h0);
    end
    ctrl_u.op(3'h2, 1'b1, 1'b1, 4'hf, 1'b0, 1'b0, 19'h0);
    ck(fsc_pkg::CYC_DESEL_CONT, 1'b0);
    $display("test deselect done");
    // Sleep overrides a read in progress; a load after exit works again
    ctrl_u.op(3'h2, 1'b0, 1'b1, 4'hf, 1'b0, 1'b0, 19'h00004);
    ctrl_u.aux(1'b0, 1'b1);
    repeat (3) @(posedge clk);
    #5;
    ck(fsc_pkg::CYC_SLEEP, 1'b0);
    chk(32'(asleep), 32'h1);
    ctrl_u.aux(1'b0, 1'b0);
    repeat (3) @(posedge clk);
    #5;
    ctrl_u.op(3'h2, 1'b0, 1'b1, 4'hf, 1'b0, 1'b0, 19'h00008);
    ck(fsc_pkg::CYC_READ, 1'b1);
    ckm(19'h00008, 4'h0, 1'b1);
    chk(32'(asleep), 32'h0);
    $display("test sleep done");
    report_and_stop();
  end
endmodule : test_fsc_cycle_decode
`default_nettype wire
